// ==== xpd_pkg.sv ====
// Constants and types for the peripheral bus address decoder.
`default_nettype none
package xpd_pkg;
  localparam logic [31:0] XPD_SYSCFG_OFF   = 32'h0000_0000;
  localparam logic [31:0] XPD_PER_EN_OFF   = 32'h0000_f024;
  localparam int          XPD_GLOBAL_BIT   = 2;
  localparam int          XPD_FIRST_CAN_MODULE_BIT     = 0;
  localparam int          XPD_SECOND_CAN_MODULE_BIT     = 1;
  localparam int          XPD_RAM1_BIT     = 2;
  localparam int          XPD_RAM2_BIT     = 3;
  localparam int          XPD_PER_EN_W     = 5;
  localparam logic [4:0]  XPD_PER_EN_RESET = 5'h05;
  localparam logic [23:0] XPD_RAM1_LO      = 24'h00e000;
  localparam logic [23:0] XPD_RAM1_HI      = 24'h00e7ff;
  localparam logic [23:0] XPD_RAM2_LO      = 24'h00c000;
  localparam logic [23:0] XPD_RAM2_HI      = 24'h00dfff;
  localparam logic [23:0] XPD_FIRST_CAN_MODULE_LO      = 24'h00ef00;
  localparam logic [23:0] XPD_FIRST_CAN_MODULE_HI      = 24'h00efff;
  localparam logic [23:0] XPD_SECOND_CAN_MODULE_LO      = 24'h00ee00;
  localparam logic [23:0] XPD_SECOND_CAN_MODULE_HI      = 24'h00eeff;
  localparam logic [23:0] XPD_SEG4_MASK    = 24'h0fffff;
  localparam int          XPD_CLK_PS       = 8000;
  localparam int          XPD_RAM_ACC_NS   = 50;
  localparam int          XPD_CAN_ACC_NS   = 100;
  localparam int          XPD_RAM_CYC      =
    (XPD_RAM_ACC_NS * 1000 + XPD_CLK_PS - 1) / XPD_CLK_PS;
  localparam int          XPD_CAN_CYC      =
    (XPD_CAN_ACC_NS * 1000 + XPD_CLK_PS - 1) / XPD_CLK_PS;
  localparam logic [3:0]  XPD_RAM_LOAD     = 4'(XPD_RAM_CYC - 1);
  localparam logic [3:0]  XPD_CAN_LOAD     = 4'(XPD_CAN_CYC - 1);
  localparam logic [1:0]  XPD_HTRANS_NSEQ  = 2'h2;
  localparam logic [1:0]  XPD_HTRANS_SEQ   = 2'h3;

  typedef enum logic [2:0] {
    XPD_TGT_NONE  = 3'b000,
    XPD_TGT_RAM1  = 3'b001,
    XPD_TGT_RAM2  = 3'b010,
    XPD_TGT_FIRST_CAN_MODULE  = 3'b011,
    XPD_TGT_SECOND_CAN_MODULE  = 3'b100,
    XPD_TGT_EXT   = 3'b101,
    XPD_TGT_BLOCK = 3'b110
  } xpd_tgt_t;

  typedef enum logic {
    XPD_ST_IDLE = 1'b0,
    XPD_ST_BUSY = 1'b1
  } xpd_state_t;
endpackage : xpd_pkg
`default_nettype wire

// ==== xpd_decoder.sv ====
// Peripheral bus address decoder with its enable registers.
//
// Design decision made here: the AHB-Lite register port.
`default_nettype none
module xpd_decoder
  import xpd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cpu_req,
  input  wire logic [23:0] cpu_addr,
  input  wire logic        cpu_write,
  input  wire logic        cpu_byte,
  input  wire logic        cpu_bitop,
  input  wire logic        cpu_stack,
  input  wire logic [15:0] cpu_wdata,
  output logic      [15:0] cpu_rdata,
  output logic             cpu_ready,
  output logic             cpu_err,
  output logic      [23:0] tgt_addr,
  output logic      [15:0] tgt_wdata,
  output logic             tgt_write,
  output logic             tgt_byte,
  output logic             ram1_sel,
  output logic             ram2_sel,
  output logic             first_can_module_sel,
  output logic             second_can_module_sel,
  output logic             ext_sel,
  input  wire logic [15:0] ram_rdata,
  input  wire logic [15:0] can_rdata,
  input  wire logic [15:0] ext_rdata,
  input  wire logic        ext_ready,
  output logic             first_can_module_pins_owned,
  output logic             second_can_module_pins_owned,
  output logic             ext_seg_four,
  output logic             rtc_unit_enable
);

  logic [4:0]  per_en_reg, per_en_next;
  logic        glob_reg, glob_next;
  logic        wr_pend_reg, wr_pend_next;
  logic [31:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic        hready_reg, hresp_reg;
  logic        addr_ok;

  // Register bus: zero wait states, always OKAY.
  assign addr_ok = hsel && hready &&
                   (htrans == XPD_HTRANS_NSEQ || htrans == XPD_HTRANS_SEQ);
  always_comb begin
    per_en_next  = per_en_reg;
    glob_next    = glob_reg;
    wr_pend_next = addr_ok && hwrite;
    wr_addr_next = haddr;
    hrdata_next  = hrdata_reg;
    if (wr_pend_reg && wr_addr_reg == XPD_SYSCFG_OFF) begin
      glob_next = hwdata[XPD_GLOBAL_BIT];
    end
    if (wr_pend_reg && wr_addr_reg == XPD_PER_EN_OFF && !glob_reg) begin
      per_en_next = hwdata[XPD_PER_EN_W-1:0];
    end
    if (addr_ok && !hwrite) begin
      hrdata_next = 32'h0000_0000;
      if (haddr == XPD_PER_EN_OFF) begin
        hrdata_next[XPD_PER_EN_W-1:0] = per_en_reg;
      end else if (haddr == XPD_SYSCFG_OFF) begin
        hrdata_next[XPD_GLOBAL_BIT] = glob_reg;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_en_reg  <= XPD_PER_EN_RESET;
      glob_reg    <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
      hrdata_reg  <= 32'h0000_0000;
      hready_reg  <= 1'b0;
      hresp_reg   <= 1'b0;
    end else begin
      per_en_reg  <= per_en_next;
      glob_reg    <= glob_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg  <= hrdata_next;
      hready_reg  <= 1'b1;
      hresp_reg   <= 1'b0;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp     = hresp_reg;
  logic first_can_module_on, second_can_module_on, ram1_on, ram2_on, can_use;
  assign first_can_module_on = glob_reg && per_en_reg[XPD_FIRST_CAN_MODULE_BIT];
  assign second_can_module_on = glob_reg && per_en_reg[XPD_SECOND_CAN_MODULE_BIT];
  assign ram1_on = glob_reg && per_en_reg[XPD_RAM1_BIT];
  assign ram2_on = glob_reg && per_en_reg[XPD_RAM2_BIT];
  assign can_use = first_can_module_on || second_can_module_on;
  function automatic logic in_rng(input logic [23:0] a,
                                  input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng
  xpd_tgt_t dec;
  always_comb begin
    dec = XPD_TGT_EXT;
    if (in_rng(cpu_addr, XPD_RAM1_LO, XPD_RAM1_HI) && ram1_on) begin
      dec = XPD_TGT_RAM1;
    end else if (in_rng(cpu_addr, XPD_RAM2_LO, XPD_RAM2_HI) && ram2_on) begin
      dec = XPD_TGT_RAM2;
    end else if (in_rng(cpu_addr, XPD_FIRST_CAN_MODULE_LO, XPD_FIRST_CAN_MODULE_HI)) begin
      dec = first_can_module_on ? XPD_TGT_FIRST_CAN_MODULE : (second_can_module_on ? XPD_TGT_BLOCK : XPD_TGT_EXT);
    end else if (in_rng(cpu_addr, XPD_SECOND_CAN_MODULE_LO, XPD_SECOND_CAN_MODULE_HI)) begin
      dec = second_can_module_on ? XPD_TGT_SECOND_CAN_MODULE : (first_can_module_on ? XPD_TGT_BLOCK : XPD_TGT_EXT);
    end
    // no bit access or stack in RAM.
    if ((dec == XPD_TGT_RAM1 || dec == XPD_TGT_RAM2) &&
        (cpu_bitop || cpu_stack)) begin
      dec = XPD_TGT_BLOCK;
    end
  end
  xpd_state_t  st_reg, st_next;
  xpd_tgt_t    tgt_reg, tgt_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] wdat_reg, wdat_next, rdat_reg, rdat_next;
  logic        wr_reg, wr_next, byte_reg, byte_next;
  logic        rdy_reg, rdy_next, err_reg, err_next;
  logic        seg4_reg;
  always_comb begin
    st_next   = st_reg;
    tgt_next  = tgt_reg;
    cnt_next  = cnt_reg;
    addr_next = addr_reg;
    wdat_next = wdat_reg;
    wr_next   = wr_reg;
    byte_next = byte_reg;
    rdat_next = rdat_reg;
    rdy_next  = 1'b0;
    err_next  = 1'b0;
    case (st_reg)
      XPD_ST_IDLE: begin
        // Not taken on the ready edge, so a held request runs once.
        if (cpu_req && !rdy_reg) begin
          byte_next = cpu_byte;
          wr_next   = cpu_write;
          wdat_next = cpu_wdata;
          // four segment lines while CAN in use.
          addr_next = can_use ? (cpu_addr & XPD_SEG4_MASK) : cpu_addr;
          case (dec)
            XPD_TGT_BLOCK: begin
              rdy_next = 1'b1;
              err_next = 1'b1;
            end
            XPD_TGT_RAM1, XPD_TGT_RAM2, XPD_TGT_FIRST_CAN_MODULE, XPD_TGT_SECOND_CAN_MODULE: begin
              tgt_next = dec;
              cnt_next = (dec == XPD_TGT_RAM1 || dec == XPD_TGT_RAM2)
                         ? XPD_RAM_LOAD : XPD_CAN_LOAD;
              st_next  = XPD_ST_BUSY;
            end
            default: begin
              tgt_next = XPD_TGT_EXT;
              st_next  = XPD_ST_BUSY;
            end
          endcase
        end
      end
      XPD_ST_BUSY: begin
        if (tgt_reg == XPD_TGT_EXT) begin
          if (ext_ready) begin
            rdat_next = ext_rdata;
            rdy_next  = 1'b1;
            tgt_next  = XPD_TGT_NONE;
            st_next   = XPD_ST_IDLE;
          end
        end else if (cnt_reg == 4'h0) begin
          rdat_next = (tgt_reg == XPD_TGT_RAM1 || tgt_reg == XPD_TGT_RAM2)
                      ? ram_rdata : can_rdata;
          rdy_next  = 1'b1;
          tgt_next  = XPD_TGT_NONE;
          st_next   = XPD_ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: begin
        st_next  = XPD_ST_IDLE;
        tgt_next = XPD_TGT_NONE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg   <= XPD_ST_IDLE;
      tgt_reg  <= XPD_TGT_NONE;
      cnt_reg  <= 4'h0;
      addr_reg <= 24'h000000;
      wdat_reg <= 16'h0000;
      rdat_reg <= 16'h0000;
      wr_reg   <= 1'b0;
      byte_reg <= 1'b0;
      rdy_reg  <= 1'b0;
      err_reg  <= 1'b0;
      seg4_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      tgt_reg  <= tgt_next;
      cnt_reg  <= cnt_next;
      addr_reg <= addr_next;
      wdat_reg <= wdat_next;
      rdat_reg <= rdat_next;
      wr_reg   <= wr_next;
      byte_reg <= byte_next;
      rdy_reg  <= rdy_next;
      err_reg  <= err_next;
      seg4_reg <= can_use;
    end
  end
  // at most one target select from the registered target.
  assign ram1_sel  = (tgt_reg == XPD_TGT_RAM1);
  assign ram2_sel  = (tgt_reg == XPD_TGT_RAM2);
  assign first_can_module_sel  = (tgt_reg == XPD_TGT_FIRST_CAN_MODULE);
  assign second_can_module_sel  = (tgt_reg == XPD_TGT_SECOND_CAN_MODULE);
  assign ext_sel   = (tgt_reg == XPD_TGT_EXT);
  assign tgt_addr  = addr_reg;
  assign tgt_wdata = wdat_reg;
  assign tgt_write = wr_reg;
  assign tgt_byte  = byte_reg;
  assign cpu_rdata = rdat_reg;
  assign cpu_ready = rdy_reg;
  assign cpu_err   = err_reg;
  assign ext_seg_four    = seg4_reg;
  // pins owned only by an enabled CAN module.
  assign first_can_module_pins_owned = per_en_reg[XPD_FIRST_CAN_MODULE_BIT] && glob_reg;
  assign second_can_module_pins_owned = per_en_reg[XPD_SECOND_CAN_MODULE_BIT] && glob_reg;
  assign rtc_unit_enable = per_en_reg[XPD_PER_EN_W-1];

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ram1;
    $rose(ram1_sel) |-> $past(ram1_on) &&
      in_rng(tgt_addr, XPD_RAM1_LO, XPD_RAM1_HI);
  endproperty
  a_ram1: assert property (p_ram1) else $error("ram1 bad select");
  property p_ram1_ext;
    $rose(ext_sel) && in_rng(tgt_addr, XPD_RAM1_LO, XPD_RAM1_HI)
      |-> !$past(ram1_on);
  endproperty
  a_ram1_ext: assert property (p_ram1_ext) else $error("ram1 went ext");
  property p_ram2;
    $rose(ram2_sel) |-> $past(ram2_on) &&
      in_rng(tgt_addr, XPD_RAM2_LO, XPD_RAM2_HI);
  endproperty
  a_ram2: assert property (p_ram2) else $error("ram2 bad select");
  property p_first_can_module;
    $rose(first_can_module_sel) |-> $past(first_can_module_on) &&
      in_rng(tgt_addr, XPD_FIRST_CAN_MODULE_LO, XPD_FIRST_CAN_MODULE_HI);
  endproperty
  a_first_can_module: assert property (p_first_can_module) else $error("first_can_module bad select");
  property p_second_can_module;
    $rose(second_can_module_sel) |-> $past(second_can_module_on) &&
      in_rng(tgt_addr, XPD_SECOND_CAN_MODULE_LO, XPD_SECOND_CAN_MODULE_HI);
  endproperty
  a_second_can_module: assert property (p_second_can_module) else $error("second_can_module bad select");
  property p_ram_len;
    $rose(ram1_sel || ram2_sel) |-> (ram1_sel || ram2_sel)[*7]
      ##1 (!ram1_sel && !ram2_sel && cpu_ready);
  endproperty
  a_ram_len: assert property (p_ram_len) else $error("ram length");
  property p_can_len;
    $rose(first_can_module_sel || second_can_module_sel) |-> ##12 (first_can_module_sel || second_can_module_sel)
      ##1 (!first_can_module_sel && !second_can_module_sel && cpu_ready);
  endproperty
  a_can_len: assert property (p_can_len) else $error("can length");
  property p_lock;
    $past(glob_reg) |-> $stable(per_en_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("enable changed");
  property p_bitop;
    $rose(ram1_sel || ram2_sel) |-> !$past(cpu_bitop) && !$past(cpu_stack);
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit access to ram");
  property p_excl;
    ext_sel |-> !(ram1_sel || ram2_sel || first_can_module_sel || second_can_module_sel);
  endproperty
  a_excl: assert property (p_excl) else $error("two targets");
  property p_seg;
    $rose(ext_sel) && $past(can_use) |-> tgt_addr[23:20] == 4'h0;
  endproperty
  a_seg: assert property (p_seg) else $error("segment lines");
  property p_gap;
    cpu_ready |=> !(ram1_sel || ram2_sel || first_can_module_sel || second_can_module_sel || ext_sel);
  endproperty
  a_gap: assert property (p_gap) else $error("request retaken");
  c_ram1: cover property ($rose(ram1_sel));
  c_second_can_module: cover property ($rose(second_can_module_sel));
  c_ext:  cover property ($rose(ext_sel) ##[1:20] cpu_ready);
  c_blk:  cover property (cpu_err);

endmodule : xpd_decoder
`default_nettype wire

// ==== xpd_cpu_model.sv ====
// Behavioural CPU core that issues data accesses to the decoder.
`default_nettype none
module xpd_cpu_model (
  input  wire logic        hclk,
  input  wire logic        cpu_ready,
  input  wire logic        cpu_err,
  input  wire logic [15:0] cpu_rdata,
  output logic             cpu_req,
  output logic      [23:0] cpu_addr,
  output logic             cpu_write,
  output logic             cpu_byte,
  output logic             cpu_bitop,
  output logic             cpu_stack,
  output logic      [15:0] cpu_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    {cpu_req, cpu_write, cpu_byte, cpu_bitop, cpu_stack} = 5'h00;
    cpu_addr  = 24'h000000;
    cpu_wdata = 16'h0000;
  end

  task automatic access(input logic [23:0] a, input logic w, b, bo, st,
                        input logic [15:0] d, output logic e,
                        output logic [15:0] q);
    int n;
    n = 0;
    @(posedge hclk);
    cpu_req <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= d;
    {cpu_write, cpu_byte, cpu_bitop, cpu_stack} <= {w, b, bo, st};
    do begin
      @(posedge hclk);
      n++;
    end while (cpu_ready !== 1'b1 && n < 64);
    e = cpu_err;
    q = cpu_rdata;
    // Released lines show a changed value so stale data cannot match.
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~d;
  endtask : access
endmodule : xpd_cpu_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking testbench for the peripheral bus address decoder.
`default_nettype none
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("unexpected at %0t got %h exp %h", $time, got, exp); \
    end \
  end
module tb_top
  import xpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] RAM_D = 16'ha5a1;
  localparam logic [15:0] CAN_D = 16'hc3c2;
  localparam logic [15:0] EXT_D = 16'he7e3;
  localparam logic [3:0]  RD = 4'h0, W = 4'h8, BO = 4'h4, ST = 4'h2;
  localparam logic [3:0]  BY = 4'h1;
  localparam logic [4:0]  R1 = 5'h01, R2 = 5'h02, C1 = 5'h04;
  localparam logic [4:0]  C2 = 5'h08, EX = 5'h10, NO = 5'h00;
  logic        hclk = 1'b0;
  logic        hresetn, hwrite, hready, hresp, ext_ready, tbyte, twr;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        cpu_req, cpu_write, cpu_byte, cpu_bitop, cpu_stack;
  logic        cpu_ready, cpu_err, tgt_write, tgt_byte;
  logic [23:0] cpu_addr, tgt_addr, taddr;
  logic [15:0] cpu_wdata, cpu_rdata, tgt_wdata, twd;
  logic        ram1_sel, ram2_sel, first_can_module_sel, second_can_module_sel, ext_sel;
  logic        first_can_module_pins_owned, second_can_module_pins_owned, ext_seg_four;
  logic        rtc_unit_enable;
  logic [4:0]  sels, mask;
  int          cnt, errors, checks;

  always #4 hclk = ~hclk;

  xpd_decoder i_xpd_decoder (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready, .hwdata, .hrdata, .hreadyout(hready), .hresp,
    .cpu_req, .cpu_addr, .cpu_write, .cpu_byte, .cpu_bitop, .cpu_stack,
    .cpu_wdata, .cpu_rdata, .cpu_ready, .cpu_err, .tgt_addr, .tgt_wdata,
    .tgt_write, .tgt_byte, .ram1_sel, .ram2_sel, .first_can_module_sel, .second_can_module_sel,
    .ext_sel, .ram_rdata(RAM_D), .can_rdata(CAN_D), .ext_rdata(EXT_D),
    .ext_ready, .first_can_module_pins_owned, .second_can_module_pins_owned, .ext_seg_four,
    .rtc_unit_enable
  );

  xpd_cpu_model i_xpd_cpu_model (
    .hclk, .cpu_ready, .cpu_err, .cpu_rdata, .cpu_req, .cpu_addr,
    .cpu_write, .cpu_byte, .cpu_bitop, .cpu_stack, .cpu_wdata
  );

  assign sels = {ext_sel, second_can_module_sel, first_can_module_sel, ram2_sel, ram1_sel};

  // The external interface answers one cycle after it is selected.
  // The record of an access is cleared while no request is raised.
  always @(posedge hclk) begin
    ext_ready <= ext_sel;
    if (cpu_req !== 1'b1) begin
      mask <= 5'h00;
      cnt <= 0;
    end else if (cpu_ready !== 1'b1) begin
      mask <= mask | sels;
      if (|sels) begin
        cnt <= cnt + 1;
        taddr <= tgt_addr;
        tbyte <= tgt_byte;
        twr <= tgt_write;
        twd <= tgt_wdata;
      end
    end
  end

  task automatic print_verdict();
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // Single transfer; a read compares the data against d.
  task automatic ahb(input logic w, input logic [31:0] a, d);
    htrans <= XPD_HTRANS_NSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : ~d;
    do @(posedge hclk); while (hready !== 1'b1);
    `CHK(hresp, 1'b0)
    if (!w) `CHK(hrdata, d)
  endtask : ahb

  task automatic acc(input logic [23:0] a, input logic [3:0] f,
                     input logic [4:0] em);
    logic        e;
    logic [15:0] q;
    logic [15:0] xd;
    i_xpd_cpu_model.access(a, f[3], f[0], f[2], f[1], a[15:0] ^ 16'h3c3c,
                           e, q);
    xd = em[4] ? EXT_D : (|em[3:2]) ? CAN_D : RAM_D;
    `CHK(mask, em)
    `CHK(e, em == NO)
    if (|em[1:0]) `CHK(cnt, XPD_RAM_CYC)
    if (|em[3:2]) `CHK(cnt, XPD_CAN_CYC)
    if (em != NO && !f[3]) `CHK(q, xd)
    if (em != NO) `CHK(tbyte, f[0])
    if (em != NO) `CHK(twr, f[3])
    if (em != NO && f[3]) `CHK(twd, a[15:0] ^ 16'h3c3c)
  endtask : acc

  initial begin
    repeat (5000) @(posedge hclk);
    errors++;
    print_verdict();
  end

  initial begin
    {hresetn, hwrite} = 2'h0;
    {htrans, haddr, hwdata} = '0;
    {errors, checks} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, XPD_PER_EN_OFF, 32'h05);
    ahb(1'b0, XPD_SYSCFG_OFF, 32'h00);
    ahb(1'b0, 32'h0000_0100, 32'h00);
    acc(24'h00e000, RD, EX);
    acc(24'h00c000, W, EX);
    ahb(1'b1, XPD_PER_EN_OFF, 32'h0e);
    ahb(1'b1, XPD_SYSCFG_OFF, 32'h04);
    ahb(1'b1, XPD_PER_EN_OFF, 32'h00);
    ahb(1'b0, XPD_PER_EN_OFF, 32'h0e);
    acc(24'h00e000, RD, R1);
    acc(24'h00e7ff, BY, R1);
    acc(24'h00e800, RD, EX);
    acc(24'h00c000, W, R2);
    acc(24'h00dfff, RD, R2);
    acc(24'h00bfff, RD, EX);
    acc(24'h00e002, BO, NO);
    acc(24'h00d000, ST, NO);
    acc(24'h00ee00, BY, C2);
    acc(24'h00eeff, W, C2);
    acc(24'h00ef00, RD, NO);
    `CHK({second_can_module_pins_owned, first_can_module_pins_owned}, 2'b10)
    `CHK({ext_seg_four, rtc_unit_enable}, 2'b10)
    acc(24'h123456, W | BY, EX);
    `CHK(taddr, 24'h023456)
    ahb(1'b1, XPD_SYSCFG_OFF, 32'h00);
    ahb(1'b1, XPD_PER_EN_OFF, 32'h01);
    ahb(1'b1, XPD_SYSCFG_OFF, 32'h04);
    ahb(1'b0, XPD_PER_EN_OFF, 32'h01);
    acc(24'h00efff, RD, C1);
    acc(24'h00ee80, RD, NO);
    acc(24'h00e400, RD, EX);
    acc(24'h00c800, RD, EX);
    `CHK({second_can_module_pins_owned, first_can_module_pins_owned}, 2'b01)
    ahb(1'b1, XPD_SYSCFG_OFF, 32'h00);
    ahb(1'b1, XPD_PER_EN_OFF, 32'h10);
    ahb(1'b1, XPD_SYSCFG_OFF, 32'h04);
    acc(24'h00ee00, RD, EX);
    acc(24'h00efff, W, EX);
    acc(24'hfff000, BY, EX);
    `CHK(taddr, 24'hfff000)
    `CHK({ext_seg_four, rtc_unit_enable}, 2'b01)
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
